// ---- design/eag_pkg.sv ----
// Purpose: shared constants for the audio routing glue
// Assumes: one clock, the codec clock output
// Notes: register offsets are byte addresses on the plain register port
package eag_pkg;

  // ****************************************
  // register port
  // ****************************************
  localparam int EAG_ADDR_W = 4;
  localparam int EAG_DATA_W = 32;
  localparam logic [EAG_ADDR_W-1:0] EAG_CTRL_OFS = 4'h0;
  localparam logic [EAG_ADDR_W-1:0] EAG_STATUS_OFS = 4'h4;

  // control register fields
  localparam int EAG_CTRL_TX_EN_BIT = 0;
  localparam int EAG_CTRL_RATE_1FS_BIT = 1;
  localparam logic EAG_CTRL_TX_EN_RST = 1'h0;
  localparam logic EAG_CTRL_RATE_1FS_RST = 1'h0;

  // status register fields
  localparam int EAG_ST_RATIO_LSB = 0;
  localparam int EAG_ST_EDGE_BIT = 2;
  localparam int EAG_ST_JUST_BIT = 3;
  localparam int EAG_ST_WLEN_LSB = 4;
  localparam int EAG_ST_I2S_BIT = 6;
  localparam int EAG_ST_TXSRC_BIT = 7;
  localparam int EAG_ST_ROUTE_LSB = 8;
  localparam int EAG_ST_MCLK_RUN_BIT = 11;
  localparam int EAG_ST_WLEN_RSV_BIT = 12;
  localparam int EAG_ST_RATIO_RSV_BIT = 13;
  localparam int EAG_ST_BUF_RDY_BIT = 14;

  // ****************************************
  // switch codes
  // ****************************************
  localparam logic [1:0] EAG_RATIO_256FS = 2'h0;
  localparam logic [1:0] EAG_RATIO_RSV = 2'h1;
  localparam logic [1:0] EAG_RATIO_384FS = 2'h2;
  localparam logic [1:0] EAG_RATIO_512FS = 2'h3;
  localparam logic [1:0] EAG_DIV_BY2 = 2'h2;
  localparam logic [1:0] EAG_DIV_BY3 = 2'h3;
  localparam logic [1:0] EAG_DIV_BY4 = 2'h0;

  localparam logic [1:0] EAG_WLEN_16 = 2'h0;
  localparam logic [1:0] EAG_WLEN_18 = 2'h1;
  localparam logic [1:0] EAG_WLEN_20 = 2'h2;
  localparam logic [1:0] EAG_WLEN_RSV = 2'h3;

  localparam logic [2:0] EAG_ROUTE_A_TO_A = 3'h0;
  localparam logic [2:0] EAG_ROUTE_A_TO_B = 3'h1;
  localparam logic [2:0] EAG_ROUTE_A_TO_C = 3'h2;
  localparam logic [2:0] EAG_ROUTE_A_TO_ALL = 3'h3;
  localparam logic [2:0] EAG_ROUTE_B_TO_ALL = 3'h4;
  localparam logic [2:0] EAG_ROUTE_A_B_PAIR = 3'h5;
  localparam logic [2:0] EAG_ROUTE_B_A_PAIR = 3'h6;
  localparam logic [2:0] EAG_ROUTE_HEADER = 3'h7;

  localparam int EAG_BUF_DEPTH = 2;

endpackage

// ---- design/eag_stream_if.sv ----
// Purpose: valid/ready stream between the glue and its buffer
// Assumes: single clock domain
// Notes: none
`timescale 1ns/1ps
interface eag_stream_if #(parameter int W = 1);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ---- design/eag_buf2.sv ----
// Purpose: two-entry buffer on the transmitter data path
// Assumes: synchronous active-high reset
// Notes: output data come straight from the head register
`timescale 1ns/1ps
module eag_buf2 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // stream ports
  eag_stream_if.snk up,
  eag_stream_if.src dn
);
  import eag_pkg::*;

  typedef struct packed {
    logic [W-1:0] head;
    logic [W-1:0] tail;
    logic [1:0] cnt;
  } eag_buf_s;

  eag_buf_s q_ff;
  eag_buf_s nxt_q;
  logic push;
  logic pop;

  assign up.ready = (q_ff.cnt != 2'(EAG_BUF_DEPTH));
  assign dn.valid = (q_ff.cnt != 2'h0);
  assign dn.data = q_ff.head;
  assign push = up.valid && up.ready;
  assign pop = dn.valid && dn.ready;

  always_comb begin
    nxt_q = q_ff;
    unique case ({push, pop})
      2'b10: begin
        if (q_ff.cnt == 2'h0) begin
          nxt_q.head = up.data;
        end else begin
          nxt_q.tail = up.data;
        end
        nxt_q.cnt = q_ff.cnt + 2'h1;
      end
      2'b01: begin
        nxt_q.head = q_ff.tail;
        nxt_q.cnt = q_ff.cnt - 2'h1;
      end
      2'b11: begin
        // full cannot push, so cnt is one here
        nxt_q.head = up.data;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

endmodule

// ---- design/eag_glue.sv ----
// Purpose: serial audio routing, transmitter clock and format glue
// Assumes: sys_clk_i is the codec clock output; pins are synchronous
// Notes: switch pins read 0 when closed, 1 when open
`timescale 1ns/1ps

// Functional notes
// - seven loopbacks for 0-6, header for 7
// - code 0 feeds input a, 1 feeds b
// - transmitter master clock is 128 Fs
// - codec clock at 1 Fs disables transmitter
// - divide by 2, 3, 4; code 01 reserved
// - switch level 0 closed, 1 open
// - edge switch 0 falling, 1 rising
// - justify switch 0 right, 1 left
// - word length 16, 18, 20; 11 reserved
// - I2S switch 0 gives normal mode
// - I2S switch 1 gives I2S mode
// - source switch low out a, high b
module eag_glue (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [eag_pkg::EAG_ADDR_W-1:0] reg_addr_i,
  input wire logic [eag_pkg::EAG_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [eag_pkg::EAG_DATA_W-1:0] reg_rdata_o,
  // switches
  input wire logic [1:0] divider_ratio_select_i,
  input wire logic tx_sample_edge_select_i,
  input wire logic tx_justify_select_i,
  input wire logic [1:0] tx_word_length_select_i,
  input wire logic tx_i2s_select_i,
  input wire logic tx_source_select_i,
  input wire logic [2:0] loopback_route_select_i,
  // codec serial port
  input wire logic codec_serial_out_a_i,
  input wire logic codec_serial_out_b_i,
  output logic codec_serial_in_a_o,
  output logic codec_serial_in_b_o,
  output logic codec_serial_in_c_o,
  // header serial inputs
  input wire logic [2:0] host_serial_header_i,
  // transmitter
  output logic tx_mclk_o,
  output logic tx_data_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  output logic src_ready_o,
  output logic tx_sample_rising_o,
  output logic tx_left_justify_o,
  output logic [1:0] tx_word_length_o,
  output logic tx_i2s_mode_o
);
  import eag_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic tx_en;
    logic rate_1fs;
    logic [1:0] div_cnt;
    logic mclk;
    logic [2:0] sdin;
    logic tx_bit;
    logic tx_live;
    logic edge_rise;
    logic left_just;
    logic [1:0] wlen;
    logic i2s;
    logic [EAG_DATA_W-1:0] rdata;
  } eag_glue_s;

  eag_glue_s st_ff;
  eag_glue_s nxt_st;

  eag_stream_if #(.W(1)) buf_in ();
  eag_stream_if #(.W(1)) buf_out ();

  logic ratio_rsv;
  logic wlen_rsv;
  logic mclk_run;
  logic [1:0] div_last;
  logic [1:0] div_high;
  logic [2:0] route;
  logic [EAG_DATA_W-1:0] status_word;

  // ****************************************
  // switch decode
  // ****************************************
  // switches are used at their pin level: open reads 1
  assign route = loopback_route_select_i;
  assign ratio_rsv = (divider_ratio_select_i == EAG_RATIO_RSV);
  assign wlen_rsv = (tx_word_length_select_i == EAG_WLEN_RSV) && !tx_i2s_select_i;
  // a 1 Fs codec clock cannot be divided to 128 Fs, so stay static
  assign mclk_run = st_ff.tx_en && !st_ff.rate_1fs && !ratio_rsv && !wlen_rsv;

  always_comb begin
    div_last = EAG_DIV_BY2 - 2'h1;
    // ratio code to the last count of the divider
    unique case (divider_ratio_select_i)
      EAG_RATIO_256FS: begin
        div_last = EAG_DIV_BY2 - 2'h1;
      end
      EAG_RATIO_384FS: begin
        div_last = EAG_DIV_BY3 - 2'h1;
      end
      EAG_RATIO_512FS: begin
        div_last = EAG_DIV_BY4 - 2'h1;
      end
      EAG_RATIO_RSV: begin
        div_last = 2'h0;
      end
    endcase
    // high for the first half, the longer half on divide by 3
    // sum widened first: three plus two does not fit two bits
    div_high = 2'((3'(div_last) + 3'h2) >> 1);
  end

  always_comb begin
    status_word = '0;
    status_word[EAG_ST_RATIO_LSB +: 2] = divider_ratio_select_i;
    status_word[EAG_ST_EDGE_BIT] = tx_sample_edge_select_i;
    status_word[EAG_ST_JUST_BIT] = tx_justify_select_i;
    status_word[EAG_ST_WLEN_LSB +: 2] = tx_word_length_select_i;
    status_word[EAG_ST_I2S_BIT] = tx_i2s_select_i;
    status_word[EAG_ST_TXSRC_BIT] = tx_source_select_i;
    status_word[EAG_ST_ROUTE_LSB +: 3] = route;
    status_word[EAG_ST_MCLK_RUN_BIT] = mclk_run;
    status_word[EAG_ST_WLEN_RSV_BIT] = wlen_rsv;
    status_word[EAG_ST_RATIO_RSV_BIT] = ratio_rsv;
    status_word[EAG_ST_BUF_RDY_BIT] = buf_in.ready;
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    nxt_st = st_ff;

    // register port; data stand for one cycle only
    nxt_st.rdata = '0;
    if (reg_wr_i && reg_addr_i == EAG_CTRL_OFS) begin
      nxt_st.tx_en = reg_wdata_i[EAG_CTRL_TX_EN_BIT];
      // software reports the codec clock rate it programmed
      nxt_st.rate_1fs = reg_wdata_i[EAG_CTRL_RATE_1FS_BIT];
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        EAG_CTRL_OFS: begin
          nxt_st.rdata[EAG_CTRL_TX_EN_BIT] = st_ff.tx_en;
          nxt_st.rdata[EAG_CTRL_RATE_1FS_BIT] = st_ff.rate_1fs;
        end
        EAG_STATUS_OFS: begin
          nxt_st.rdata = status_word;
        end
        default: begin
          nxt_st.rdata = '0;
        end
      endcase
    end

    // master clock divider
    if (!mclk_run) begin
      nxt_st.div_cnt = 2'h0;
      nxt_st.mclk = 1'b0;
    end else begin
      // the counter wraps at the last count of the ratio
      if (st_ff.div_cnt >= div_last) begin
        nxt_st.div_cnt = 2'h0;
      end else begin
        nxt_st.div_cnt = st_ff.div_cnt + 2'h1;
      end
      nxt_st.mclk = (nxt_st.div_cnt < div_high);
    end

    // loopback routing onto codec inputs a, b, c
    unique case (route)
      EAG_ROUTE_A_TO_A: begin
        nxt_st.sdin[0] = codec_serial_out_a_i;
        nxt_st.sdin[1] = 1'b0;
        nxt_st.sdin[2] = 1'b0;
      end
      EAG_ROUTE_A_TO_B: begin
        nxt_st.sdin[0] = 1'b0;
        nxt_st.sdin[1] = codec_serial_out_a_i;
        nxt_st.sdin[2] = 1'b0;
      end
      EAG_ROUTE_A_TO_C: begin
        nxt_st.sdin[0] = 1'b0;
        nxt_st.sdin[1] = 1'b0;
        nxt_st.sdin[2] = codec_serial_out_a_i;
      end
      EAG_ROUTE_A_TO_ALL: begin
        nxt_st.sdin[0] = codec_serial_out_a_i;
        nxt_st.sdin[1] = codec_serial_out_a_i;
        nxt_st.sdin[2] = codec_serial_out_a_i;
      end
      EAG_ROUTE_B_TO_ALL: begin
        nxt_st.sdin[0] = codec_serial_out_b_i;
        nxt_st.sdin[1] = codec_serial_out_b_i;
        nxt_st.sdin[2] = codec_serial_out_b_i;
      end
      // the two pair codes leave input c at zero
      EAG_ROUTE_A_B_PAIR: begin
        nxt_st.sdin[0] = codec_serial_out_a_i;
        nxt_st.sdin[1] = codec_serial_out_b_i;
        nxt_st.sdin[2] = 1'b0;
      end
      EAG_ROUTE_B_A_PAIR: begin
        nxt_st.sdin[0] = codec_serial_out_b_i;
        nxt_st.sdin[1] = codec_serial_out_a_i;
        nxt_st.sdin[2] = 1'b0;
      end
      EAG_ROUTE_HEADER: begin
        nxt_st.sdin[0] = host_serial_header_i[0];
        nxt_st.sdin[1] = host_serial_header_i[1];
        nxt_st.sdin[2] = host_serial_header_i[2];
      end
    endcase

    // transmitter data source
    if (tx_source_select_i) begin
      nxt_st.tx_bit = codec_serial_out_b_i;
    end else begin
      nxt_st.tx_bit = codec_serial_out_a_i;
    end
    // only a running master clock makes the path live
    nxt_st.tx_live = mclk_run;

    // transmitter format
    nxt_st.edge_rise = tx_sample_edge_select_i;
    nxt_st.i2s = tx_i2s_select_i;
    // justification and length are meaningless in I2S mode
    if (tx_i2s_select_i) begin
      nxt_st.left_just = 1'b0;
    end else begin
      nxt_st.left_just = tx_justify_select_i;
    end
    // a reserved length keeps the last legal setting
    unique case (tx_word_length_select_i)
      EAG_WLEN_16: begin
        nxt_st.wlen = EAG_WLEN_16;
      end
      EAG_WLEN_18: begin
        nxt_st.wlen = EAG_WLEN_18;
      end
      EAG_WLEN_20: begin
        nxt_st.wlen = EAG_WLEN_20;
      end
      EAG_WLEN_RSV: begin
        nxt_st.wlen = st_ff.wlen;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
      st_ff.tx_en <= EAG_CTRL_TX_EN_RST;
      st_ff.rate_1fs <= EAG_CTRL_RATE_1FS_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************
  // transmitter buffer
  // ****************************************
  // a stall by the transmitter is absorbed by two words, then pushes back
  // a bit refused while full is lost at the source, not later
  assign buf_in.valid = st_ff.tx_live;
  assign buf_in.data = st_ff.tx_bit;
  assign buf_out.ready = tx_ready_i;

  eag_buf2 #(.W(1)) u_buf (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .up(buf_in),
    .dn(buf_out)
  );

  // ****************************************
  // outputs
  // ****************************************
  // data outputs come from registers, the handshakes do not
  assign reg_rdata_o = st_ff.rdata;
  assign codec_serial_in_a_o = st_ff.sdin[0];
  assign codec_serial_in_b_o = st_ff.sdin[1];
  assign codec_serial_in_c_o = st_ff.sdin[2];
  assign tx_mclk_o = st_ff.mclk;
  assign tx_data_o = buf_out.data;
  assign tx_valid_o = buf_out.valid;
  assign src_ready_o = buf_in.ready;
  assign tx_sample_rising_o = st_ff.edge_rise;
  assign tx_left_justify_o = st_ff.left_just;
  assign tx_word_length_o = st_ff.wlen;
  assign tx_i2s_mode_o = st_ff.i2s;

endmodule

// ---- dv/eag_glue_props.sv ----
// Purpose: port-level checks for eag_glue
// Assumes: one clock, synchronous active-high reset
// Notes: bound to every eag_glue instance
`timescale 1ns/1ps
module eag_glue_props (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // switches
  input wire logic [1:0] divider_ratio_select_i,
  input wire logic tx_sample_edge_select_i,
  input wire logic tx_justify_select_i,
  input wire logic [1:0] tx_word_length_select_i,
  input wire logic tx_i2s_select_i,
  input wire logic [2:0] loopback_route_select_i,
  // serial data
  input wire logic codec_serial_out_a_i,
  input wire logic [2:0] host_serial_header_i,
  input wire logic codec_serial_in_a_o,
  input wire logic codec_serial_in_b_o,
  input wire logic codec_serial_in_c_o,
  // transmitter
  input wire logic tx_mclk_o,
  input wire logic tx_sample_rising_o,
  input wire logic tx_left_justify_o,
  input wire logic [1:0] tx_word_length_o,
  input wire logic tx_i2s_mode_o
);
  // ***
  // checks
  // ***
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  property p_route_a; !rst_i && loopback_route_select_i == 3'h0 |=> codec_serial_in_a_o == $past(codec_serial_out_a_i)
    && !codec_serial_in_b_o && !codec_serial_in_c_o; endproperty
  a_route_a: assert property (p_route_a) else $error("route 0 wrong");
  property p_route_hdr; !rst_i && loopback_route_select_i == 3'h7 |=>
    {codec_serial_in_c_o, codec_serial_in_b_o, codec_serial_in_a_o} == $past(host_serial_header_i); endproperty
  a_route_hdr: assert property (p_route_hdr) else $error("header route wrong");
  property p_edge; !rst_i |=> tx_sample_rising_o == $past(tx_sample_edge_select_i); endproperty
  a_edge: assert property (p_edge) else $error("edge wrong");
  property p_just; !rst_i |=> tx_left_justify_o == $past(tx_justify_select_i && !tx_i2s_select_i); endproperty
  a_just: assert property (p_just) else $error("justify wrong");
  property p_i2s; !rst_i |=> tx_i2s_mode_o == $past(tx_i2s_select_i); endproperty
  a_i2s: assert property (p_i2s) else $error("i2s wrong");
  property p_wlen; !rst_i && tx_word_length_select_i != 2'h3 |=> tx_word_length_o == $past(tx_word_length_select_i);
  endproperty
  a_wlen: assert property (p_wlen) else $error("word length wrong");
  property p_rsv; !rst_i && divider_ratio_select_i == 2'h1 |=> !tx_mclk_o; endproperty
  a_rsv: assert property (p_rsv) else $error("mclk runs on reserved ratio");
  property p_hold; !rst_i && tx_mclk_o [*2] |=> !tx_mclk_o; endproperty
  a_hold: assert property (p_hold) else $error("mclk high too long");
endmodule

bind eag_glue eag_glue_props u_props (.*);

// ---- dv/eag_tx_model.sv ----
// Purpose: transmitter stand-in: random ready, mclk period, popped bits
// Assumes: all on sys_clk_i
// Notes: ready drops at random even when not stalled
`timescale 1ns/1ps
module eag_tx_model (
  // inputs
  input wire logic sys_clk_i,
  input wire logic tx_mclk_o,
  input wire logic tx_data_o,
  input wire logic tx_valid_o,
  input wire logic stall_i,
  // outputs
  output logic tx_ready_i = 1'b0,
  output int period = 0,
  output int pops = 0,
  output logic last_bit = 1'b0
);
  logic prev = 1'b0;
  int cnt = 0;
  always @(posedge sys_clk_i) begin
    prev <= tx_mclk_o;
    cnt <= cnt + 1;
    if (tx_mclk_o && !prev) begin
      period <= cnt;
      cnt <= 1;
    end
    if (tx_valid_o && tx_ready_i) begin
      pops <= pops + 1;
      last_bit <= tx_data_o;
    end
    tx_ready_i <= !stall_i && ($urandom_range(3) != 0);
  end
endmodule

// ---- dv/eag_glue_bench.sv ----
// Purpose: self-checking bench for eag_glue
// Assumes: 25 MHz clock, sync reset
// Notes: expectations built from switch values
`timescale 1ns/1ps
module eag_glue_bench;
  import eag_pkg::*;
  logic sys_clk_i, rst_i, reg_wr_i, reg_rd_i, stall, last_bit;
  logic [EAG_ADDR_W-1:0] reg_addr_i;
  logic [EAG_DATA_W-1:0] reg_wdata_i, reg_rdata_o, rd;
  logic [1:0] divider_ratio_select_i, tx_word_length_select_i, tx_word_length_o;
  logic tx_sample_edge_select_i, tx_justify_select_i, tx_i2s_select_i, tx_source_select_i;
  logic [2:0] loopback_route_select_i, host_serial_header_i;
  logic codec_serial_out_a_i, codec_serial_out_b_i, codec_serial_in_a_o, codec_serial_in_b_o, codec_serial_in_c_o;
  logic tx_mclk_o, tx_data_o, tx_valid_o, tx_ready_i, src_ready_o, tx_sample_rising_o, tx_left_justify_o, tx_i2s_mode_o;
  logic [1:0] rat[3] = '{2'h0, 2'h2, 2'h3};
  int dv[3] = '{2, 3, 4};
  int fails, checks_done, period, pops, p0;
  logic [1:0] wl = 2'h0;
  eag_glue DUT (.*);
  eag_tx_model u_tx (.sys_clk_i, .tx_mclk_o, .tx_data_o, .tx_valid_o, .stall_i(stall), .tx_ready_i, .period, .pops,
    .last_bit);
  // ***
  // tasks
  // ***
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s exp=%h seen=%h", what, exp, seen);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge sys_clk_i);
    rd = reg_rdata_o;
  endtask
  task automatic quiet(input string what);
    repeat (3) @(posedge sys_clk_i);
    repeat (8) begin
      @(negedge sys_clk_i);
      chk(what, tx_mclk_o, 0);
    end
    @(posedge sys_clk_i);
  endtask
  function automatic logic [2:0] route(input logic [2:0] s, input logic a, input logic b, input logic [2:0] h);
    case (s)
      3'h0: return {2'h0, a};
      3'h1: return {1'b0, a, 1'b0};
      3'h2: return {a, 2'h0};
      3'h3: return {3{a}};
      3'h4: return {3{b}};
      3'h5: return {1'b0, b, a};
      3'h6: return {1'b0, a, b};
      default: return h;
    endcase
  endfunction
  task end_sim;
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ***
  // run
  // ***
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    #800000;
    fails++;
    end_sim;
  end
  initial begin
    p0 = $urandom(32'h3598BE68);
    rst_i = 1'b1;
    {reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i, stall, divider_ratio_select_i, tx_word_length_select_i} = '0;
    {tx_sample_edge_select_i, tx_justify_select_i, tx_i2s_select_i, tx_source_select_i} = '0;
    {loopback_route_select_i, host_serial_header_i, codec_serial_out_a_i, codec_serial_out_b_i} = '0;
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    reg_rd(EAG_CTRL_OFS);
    chk("ctrl reset", rd, 0);
    reg_wr(4'h8, '1);
    reg_wr(EAG_STATUS_OFS, '1);
    reg_rd(4'h8);
    chk("unmapped", rd, 0);
    reg_rd(EAG_CTRL_OFS);
    chk("ctrl kept", rd, 0);
    repeat (16) begin
      @(posedge sys_clk_i);
      {divider_ratio_select_i, tx_sample_edge_select_i, tx_justify_select_i, tx_word_length_select_i,
        tx_i2s_select_i, tx_source_select_i, loopback_route_select_i} <= 11'($urandom);
      reg_rd(EAG_STATUS_OFS);
      chk("status", rd & 32'h37FF, {18'h0, divider_ratio_select_i == 2'h1,
        tx_word_length_select_i == 2'h3 && !tx_i2s_select_i, 1'b0,
        loopback_route_select_i, tx_source_select_i, tx_i2s_select_i, tx_word_length_select_i,
        tx_justify_select_i, tx_sample_edge_select_i, divider_ratio_select_i});
      if (tx_word_length_select_i != EAG_WLEN_RSV) wl = tx_word_length_select_i;
      chk("format", {tx_sample_rising_o, tx_left_justify_o, tx_word_length_o, tx_i2s_mode_o},
        {tx_sample_edge_select_i, tx_justify_select_i && !tx_i2s_select_i, wl, tx_i2s_select_i});
    end
    for (int s = 0; s < 8; s++) repeat (4) begin
      @(posedge sys_clk_i);
      {codec_serial_out_a_i, codec_serial_out_b_i, host_serial_header_i} <= 5'($urandom);
      loopback_route_select_i <= 3'(s);
      @(negedge sys_clk_i);
      @(negedge sys_clk_i);
      chk("route", {codec_serial_in_c_o, codec_serial_in_b_o, codec_serial_in_a_o}, route(loopback_route_select_i,
        codec_serial_out_a_i, codec_serial_out_b_i, host_serial_header_i));
    end
    // host has set the codec clock source and a supported port mode
    reg_wr(EAG_CTRL_OFS, 32'h1);
    {tx_word_length_select_i, tx_i2s_select_i} <= 3'h0;
    foreach (rat[i]) begin
      divider_ratio_select_i <= rat[i];
      repeat (20) @(posedge sys_clk_i);
      chk("mclk period", period, dv[i]);
    end
    divider_ratio_select_i <= EAG_RATIO_RSV;
    quiet("ratio reserved");
    {divider_ratio_select_i, tx_word_length_select_i} <= 4'h3;
    quiet("wlen reserved");
    tx_word_length_select_i <= EAG_WLEN_16;
    reg_wr(EAG_CTRL_OFS, 32'h3);
    quiet("rate 1fs");
    reg_rd(EAG_STATUS_OFS);
    chk("mclk run", rd[EAG_ST_MCLK_RUN_BIT], 0);
    reg_wr(EAG_CTRL_OFS, 32'h1);
    for (int s = 0; s < 2; s++) begin
      tx_source_select_i <= s[0];
      {codec_serial_out_a_i, codec_serial_out_b_i} <= s ? 2'h1 : 2'h2;
      stall <= 1'b1;
      repeat (12) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      chk("buffer full", {src_ready_o, tx_valid_o}, 2'h1);
      @(posedge sys_clk_i);
      stall <= 1'b0;
      p0 = pops;
      repeat (20) @(posedge sys_clk_i);
      chk("tx bit", last_bit, 1);
      chk("pops", 32'(pops - p0 > 4), 1);
    end
    reg_wr(EAG_CTRL_OFS, 32'h0);
    repeat (20) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk("drained", {src_ready_o, tx_valid_o}, 2'h2);
    end_sim;
  end
endmodule
